// ===== pkg/next_page_pkg.sv
// Constants and carrier types for the received next page register bank.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package next_page_pkg;
    // Byte offsets
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [3:0] NEXT_PAGE_RX_OFFSET = 4'h8;
    // Field positions of the received page word
    localparam int MORE_PAGES_BIT = 15;
    localparam int ACK_BIT = 14;
    localparam int MESSAGE_PAGE_BIT = 13;
    localparam int COMPLY_BIT = 12;
    localparam int TOGGLE_BIT = 11;
    localparam int CODE_MSB = 10;
    localparam int CODE_LSB = 0;
    // Reset word: message page set, code holds the null page message
    localparam logic [10:0] NULL_PAGE_CODE = 11'h001;
    localparam logic [15:0] NEXT_PAGE_RX_RESET = 16'h2001;
    // Software writable bits: 15, 13, 12 and 10:0
    localparam logic [15:0] NEXT_PAGE_RX_SW_MASK = 16'hb7ff;
    // Control and status fields
    localparam int CAPTURE_EN_BIT = 0;
    localparam logic CAPTURE_EN_RESET = 1'b1;
    localparam int NEW_PAGE_BIT = 0;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    typedef struct packed {
        logic more_pages;
        logic ack;
        logic message_page;
        logic comply;
        logic toggle;
        logic [10:0] code;
    } page_word_s;
endpackage : next_page_pkg

// ===== hdl/masked_field_reg.sv
// Field register loaded by hardware or by software under a write mask.
// Assumes both loads come from the same clock domain; hardware load wins.
`timescale 1ns/1ps
`default_nettype none
module masked_field_reg #(
    parameter int W = 16,
    parameter logic [W-1:0] RST = '0,
    parameter logic [W-1:0] SW_MASK = '1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic hw_load_in,
    input wire logic [W-1:0] hw_val_in,
    input wire logic sw_load_in,
    input wire logic [W-1:0] sw_lane_in,
    input wire logic [W-1:0] sw_val_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] sw_keep;
    assign sw_keep = SW_MASK & sw_lane_in;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            q_out <= RST;
        end else if (hw_load_in) begin
            q_out <= hw_val_in;
        end else if (sw_load_in) begin
            q_out <= (q_out & ~sw_keep) | (sw_val_in & sw_keep);
        end
    end
endmodule : masked_field_reg
`default_nettype wire

// ===== hdl/next_page_rx_reg.sv
// Received next page register with its Avalon-MM slave, control and status.
// Assumes the negotiation logic drives the page word and its load strobe on MCLK_IN.
`timescale 1ns/1ps
`default_nettype none
module next_page_rx_reg (
    input wire logic MCLK_IN,
    input wire logic RESET_IN,
    input wire logic [3:0] AVS_ADDRESS_IN,
    input wire logic AVS_READ_IN,
    input wire logic AVS_WRITE_IN,
    input wire logic [31:0] AVS_WRITEDATA_IN,
    input wire logic [3:0] AVS_BYTEENABLE_IN,
    output logic [31:0] AVS_READDATA_OUT,
    output logic AVS_WAITREQUEST_OUT,
    input wire next_page_pkg::page_word_s PAGE_WORD_IN,
    input wire logic PAGE_LOAD_IN,
    output logic [15:0] NEXT_PAGE_RX_OUT
);
    import next_page_pkg::*;

    logic ack_q;
    logic ack_d;
    logic capture_en_q;
    logic new_page_q;
    logic hw_load;
    logic wr_fire;
    logic [15:0] lane_mask;
    logic [15:0] captured_word;
    logic [15:0] next_page_rx_reg;
    logic [31:0] rdata_d;

    // Bus handshake: one wait cycle, then one answer cycle
    assign ack_d = (AVS_READ_IN | AVS_WRITE_IN) & ~ack_q;
    assign wr_fire = AVS_WRITE_IN & ack_q;
    assign lane_mask = {{8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};

    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            ack_q <= 1'b0;
            AVS_WAITREQUEST_OUT <= 1'b1;
        end else begin
            ack_q <= ack_d;
            AVS_WAITREQUEST_OUT <= ~ack_d;
        end
    end

    a_idle_no_answer: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        !AVS_READ_IN && !AVS_WRITE_IN |=> AVS_WAITREQUEST_OUT)
        else $error("answer given without a request");

    a_bus_reset: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        $fell(RESET_IN) |-> AVS_WAITREQUEST_OUT && AVS_READDATA_OUT == UNMAPPED_READ &&
            capture_en_q == CAPTURE_EN_RESET)
        else $error("bus or control state wrong after reset");

    // Capture enable written by software
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            capture_en_q <= CAPTURE_EN_RESET;
        end else if (wr_fire && AVS_ADDRESS_IN == CTRL_OFFSET && AVS_BYTEENABLE_IN[0]) begin
            capture_en_q <= AVS_WRITEDATA_IN[CAPTURE_EN_BIT];
        end
    end

    a_capture_en_write: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        wr_fire && AVS_ADDRESS_IN == CTRL_OFFSET && AVS_BYTEENABLE_IN[0] |=>
            capture_en_q == $past(AVS_WRITEDATA_IN[CAPTURE_EN_BIT]))
        else $error("capture enable not written");

    assign hw_load = PAGE_LOAD_IN & capture_en_q;

    a_refused_load: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        PAGE_LOAD_IN && !capture_en_q && !wr_fire |=>
            $stable(NEXT_PAGE_RX_OUT) && $stable(new_page_q))
        else $error("page loaded while capture disabled");

    // Received word as stored; toggle bit kept inverted
    assign captured_word = {PAGE_WORD_IN.more_pages,
                            PAGE_WORD_IN.ack,
                            PAGE_WORD_IN.message_page,
                            PAGE_WORD_IN.comply,
                            ~PAGE_WORD_IN.toggle,
                            PAGE_WORD_IN.code};

    // New page flag: set by capture, cleared by writing one; set wins
    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            new_page_q <= 1'b0;
        end else if (hw_load) begin
            new_page_q <= 1'b1;
        end else if (wr_fire && AVS_ADDRESS_IN == STATUS_OFFSET && AVS_BYTEENABLE_IN[0] &&
                     AVS_WRITEDATA_IN[NEW_PAGE_BIT]) begin
            new_page_q <= 1'b0;
        end
    end

    a_new_page_set: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        hw_load |=> new_page_q)
        else $error("new page flag not set by capture");

    a_new_page_clear: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        wr_fire && AVS_ADDRESS_IN == STATUS_OFFSET && AVS_BYTEENABLE_IN[0] && AVS_WRITEDATA_IN[NEW_PAGE_BIT] &&
            !hw_load |=> !new_page_q)
        else $error("new page flag not cleared by write");

    masked_field_reg #(
        .W(16),
        .RST(NEXT_PAGE_RX_RESET),
        .SW_MASK(NEXT_PAGE_RX_SW_MASK)
    ) u_next_page_rx (
        .clk_in(MCLK_IN),
        .rst_in(RESET_IN),
        .hw_load_in(hw_load),
        .hw_val_in(captured_word),
        .sw_load_in(wr_fire && AVS_ADDRESS_IN == NEXT_PAGE_RX_OFFSET),
        .sw_lane_in(lane_mask),
        .sw_val_in(AVS_WRITEDATA_IN[15:0]),
        .q_out(next_page_rx_reg)
    );

    assign NEXT_PAGE_RX_OUT = next_page_rx_reg;

    // Read mux; reads touch no state
    always_comb begin
        rdata_d = UNMAPPED_READ;
        case (AVS_ADDRESS_IN)
            CTRL_OFFSET: rdata_d[CAPTURE_EN_BIT] = capture_en_q;
            STATUS_OFFSET: rdata_d[NEW_PAGE_BIT] = new_page_q;
            NEXT_PAGE_RX_OFFSET: rdata_d[15:0] = next_page_rx_reg;
            default: rdata_d = UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge MCLK_IN) begin
        if (RESET_IN) begin
            AVS_READDATA_OUT <= UNMAPPED_READ;
        end else if (ack_d && AVS_READ_IN) begin
            AVS_READDATA_OUT <= rdata_d;
        end
    end

    a_read_data_hold: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        !(ack_d && AVS_READ_IN) |=> $stable(AVS_READDATA_OUT))
        else $error("read data changed without a read");

    a_read_page_data: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        AVS_READ_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == NEXT_PAGE_RX_OFFSET |->
            AVS_READDATA_OUT == {16'h0000, $past(NEXT_PAGE_RX_OUT)})
        else $error("page register read data wrong");

    a_unmapped_read: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        AVS_READ_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN != CTRL_OFFSET &&
            AVS_ADDRESS_IN != STATUS_OFFSET && AVS_ADDRESS_IN != NEXT_PAGE_RX_OFFSET |->
            AVS_READDATA_OUT == UNMAPPED_READ)
        else $error("unmapped read not zero");

    a_upper_read_zero: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        !AVS_WAITREQUEST_OUT |-> AVS_READDATA_OUT[31:16] == 16'h0000)
        else $error("upper read data not zero");

    // Field checks after capture, without capture and after reset; read and bus answer checks

    a_rx_capture_word: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        hw_load |=> NEXT_PAGE_RX_OUT == {$past(PAGE_WORD_IN.more_pages), $past(PAGE_WORD_IN.ack),
            $past(PAGE_WORD_IN.message_page), $past(PAGE_WORD_IN.comply), ~$past(PAGE_WORD_IN.toggle),
            $past(PAGE_WORD_IN.code)})
        else $error("received page word not captured");

    a_more_pages_bit: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        hw_load |=> NEXT_PAGE_RX_OUT[MORE_PAGES_BIT] == $past(PAGE_WORD_IN.more_pages))
        else $error("more pages bit wrong");

    a_ack_read_only: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        !hw_load |=> NEXT_PAGE_RX_OUT[ACK_BIT] == $past(NEXT_PAGE_RX_OUT[ACK_BIT]))
        else $error("acknowledge bit changed without a capture");

    a_reset_word: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        $fell(RESET_IN) |-> NEXT_PAGE_RX_OUT == NEXT_PAGE_RX_RESET && new_page_q == 1'b0)
        else $error("reset value of page register wrong");

    a_comply_mirror: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        hw_load |=> NEXT_PAGE_RX_OUT[COMPLY_BIT] == $past(PAGE_WORD_IN.comply))
        else $error("comply bit does not mirror partner");

    a_ack_capture: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        hw_load |=> NEXT_PAGE_RX_OUT[ACK_BIT] == $past(PAGE_WORD_IN.ack))
        else $error("acknowledge bit not captured");

    a_msg_page_bit: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        hw_load |=> NEXT_PAGE_RX_OUT[MESSAGE_PAGE_BIT] == $past(PAGE_WORD_IN.message_page))
        else $error("message page bit not captured");

    a_toggle_inverse: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        hw_load |=> NEXT_PAGE_RX_OUT[TOGGLE_BIT] == ~$past(PAGE_WORD_IN.toggle))
        else $error("toggle echo not inverted");

    a_toggle_read_only: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        !hw_load |=> $stable(NEXT_PAGE_RX_OUT[TOGGLE_BIT]))
        else $error("toggle echo changed without a capture");

    a_code_field: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        hw_load |=> NEXT_PAGE_RX_OUT[CODE_MSB:CODE_LSB] == $past(PAGE_WORD_IN.code))
        else $error("code field not captured");

    a_null_code_reset: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        $fell(RESET_IN) |-> NEXT_PAGE_RX_OUT[CODE_MSB:CODE_LSB] == NULL_PAGE_CODE)
        else $error("code field not null page after reset");

    a_read_no_effect: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        AVS_READ_IN && !PAGE_LOAD_IN |=> $stable(NEXT_PAGE_RX_OUT) && $stable(new_page_q) && $stable(capture_en_q))
        else $error("read changed register state");

    a_bus_answer: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
        (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT)
        else $error("bus answer not one cycle after request");
endmodule : next_page_rx_reg
`default_nettype wire

// ===== tb/page_partner.sv
// Link partner model: hands one received page word to the block per request.
// Assumes requests arrive on the block clock; load pulse follows one cycle later.
`timescale 1ns/1ps
`default_nettype none
module page_partner (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [15:0] word_in,
    output next_page_pkg::page_word_s page_out,
    output logic load_out
);
    initial begin
        load_out = 1'b0;
        page_out = '0;
    end
    // One page per request; word lines scrambled once released
    always @(posedge clk_in) begin
        load_out <= go_in;
        page_out <= go_in ? word_in : ~page_out;
    end
endmodule : page_partner
`default_nettype wire

// ===== tb/tb_next_page_rx_reg.sv
// Self-checking bench for the received next page register bank.
// Assumes the page_partner model and the register bank design files.
`timescale 1ns/1ps
`default_nettype none
module tb_next_page_rx_reg;
    import next_page_pkg::*;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, go = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] be = 4'h3;
    logic [31:0] wd = 32'h0, rdat, r2;
    logic [15:0] gw = 16'h0, npo;
    logic [31:0] rdo;
    logic wrq, ld;
    page_word_s pw;
    int fails = 0, comparisons = 0;
    always #4 clk = ~clk;
    page_partner lp (.clk_in(clk), .go_in(go), .word_in(gw), .page_out(pw), .load_out(ld));
    next_page_rx_reg dut (.MCLK_IN(clk), .RESET_IN(rst), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd),
        .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdo),
        .AVS_WAITREQUEST_OUT(wrq), .PAGE_WORD_IN(pw), .PAGE_LOAD_IN(ld), .NEXT_PAGE_RX_OUT(npo));
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wrq !== 1'b0 && n < 50);
        r = rdo;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50) fails++;
        @(posedge clk);
    endtask : bus
    task automatic page(input logic [15:0] w);
        go <= 1'b1;
        gw <= w;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : page
    task automatic t_reset;
        chk(32'h1, {31'h0, wrq});
        chk(UNMAPPED_READ, rdo);
        bus(1'b0, NEXT_PAGE_RX_OFFSET, 0, rdat);
        chk(32'h0000_2001, rdat);
        chk(32'h0000_2001, {16'h0, npo});
        bus(1'b0, CTRL_OFFSET, 0, rdat);
        chk(32'h1, rdat);
        bus(1'b0, STATUS_OFFSET, 0, rdat);
        chk(32'h0, rdat);
    endtask : t_reset
    task automatic t_capture;
        logic [15:0] w[3] = '{16'hd955, 16'h4aaa, 16'h27ff};
        foreach (w[i]) begin
            page(w[i]);
            chk({16'h0, w[i] ^ 16'h0800}, {16'h0, npo});
            bus(1'b0, NEXT_PAGE_RX_OFFSET, 0, rdat);
            chk({16'h0, w[i] ^ 16'h0800}, rdat);
        end
        bus(1'b0, NEXT_PAGE_RX_OFFSET, 0, r2);
        chk(rdat, r2);
        bus(1'b0, STATUS_OFFSET, 0, rdat);
        chk(32'h1, rdat);
        bus(1'b1, STATUS_OFFSET, 32'h1, r2);
        bus(1'b0, STATUS_OFFSET, 0, rdat);
        chk(32'h0, rdat);
    endtask : t_capture
    task automatic t_write;
        logic [15:0] old;
        logic [15:0] cur;
        old = npo;
        cur = old & ~NEXT_PAGE_RX_SW_MASK;
        bus(1'b1, NEXT_PAGE_RX_OFFSET, 32'hffff_0000, rdat);
        bus(1'b0, NEXT_PAGE_RX_OFFSET, 0, rdat);
        chk({16'h0, cur}, rdat);
        cur = cur | NEXT_PAGE_RX_SW_MASK;
        bus(1'b1, NEXT_PAGE_RX_OFFSET, 32'h0000_ffff, rdat);
        bus(1'b0, NEXT_PAGE_RX_OFFSET, 0, rdat);
        chk({16'h0, cur}, rdat);
        be <= 4'h1;
        bus(1'b1, NEXT_PAGE_RX_OFFSET, 32'h0, rdat);
        be <= 4'h3;
        cur = cur & 16'hff00;
        bus(1'b0, NEXT_PAGE_RX_OFFSET, 0, rdat);
        chk({16'h0, cur}, rdat);
        bus(1'b1, 4'hc, 32'hffff, rdat);
        bus(1'b0, 4'hc, 0, rdat);
        chk(UNMAPPED_READ, rdat);
        bus(1'b1, CTRL_OFFSET, 32'h0, rdat);
        bus(1'b0, CTRL_OFFSET, 0, rdat);
        chk(32'h0, rdat);
        page(16'hffff);
        chk({16'h0, cur}, {16'h0, npo});
        bus(1'b0, STATUS_OFFSET, 0, rdat);
        chk(32'h0, rdat);
        bus(1'b1, CTRL_OFFSET, 32'h1, rdat);
        bus(1'b0, CTRL_OFFSET, 0, rdat);
        chk(32'h1, rdat);
        page(16'h1234);
        chk({16'h0, 16'h1a34}, {16'h0, npo});
        bus(1'b1, CTRL_OFFSET, 32'h0, rdat);
    endtask : t_write
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_capture();
        t_write();
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        end_of_test();
    end
    initial begin
        #20000;
        fails++;
        end_of_test();
    end
endmodule : tb_next_page_rx_reg
`default_nettype wire
